// ---- common/fsp_pkg.sv ----
// Constants, types and the polling algorithm summary for the flash status poller
// Function
// RULE1: Busy-time reads return the status byte
// RULE2: Program: completion bit is inverted written data
// RULE3: Programmed location then returns stored bit
// RULE4: Erase: completion bit 0, then 1
// RULE5: Suspend: completion bit 0, then 1
// RULE6: Buffered program: poll last loaded word
// RULE7: Primary toggle inverts each read while busy
// RULE8: Primary toggle stops once erase suspended
// RULE9: Error bit set on operation failure
// RULE10: After error, send read/reset first
// RULE11: Erase timer bit 1 once erase runs
// RULE12: Alternative toggle inverts in erasing blocks
// RULE13: Abort bit set on aborted buffered operation
// RULE14: After abort, send three-cycle reset
// RULE15: Success returns device to read mode
// RULE16: Suspend: other blocks read as array
// RULE17: Chip CRC: completion bit inverts last word
// RULE18: Poll last programmed or erasing-block address
// RULE19: Blank check uses toggle method
// RULE20: Ignore undefined status bits
// RULE21: After reset wake-up, read mode, status clear
// RULE22: Toggles advance once per completed read
package fsp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 100;
  localparam int ACC_NS = 110;
  localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_NS = 100;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_HIGH_NS = 100;
  localparam int BUS_HIGH_CYC = (BUS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_NS = 50000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 16;
  ////////////////////////////////////////////////////////////////////////////
  // Status byte field positions
  localparam int POS_COMPLETION = 7;
  localparam int POS_PRIMARY_TOGGLE = 6;
  localparam int POS_ERROR = 5;
  localparam int POS_ERASE_TIMER = 3;
  localparam int POS_ALT_TOGGLE = 2;
  localparam int POS_BUFFER_ABORT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Recovery commands (x16 addressing)
  localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [11:0] ADDR_UNLOCK_A = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK_B = 12'h2AA;
  localparam logic [1:0] SEQ_FULL_START = 2'h0;
  localparam logic [1:0] SEQ_LAST = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic {FSP_METHOD_DATA, FSP_METHOD_TOGGLE} fsp_method_e;
  typedef enum logic [1:0] {FSP_RES_PASS, FSP_RES_ERROR, FSP_RES_ABORT, FSP_RES_TIMEOUT} fsp_result_e;
endpackage

// ---- common/fsp_bus_if.sv ----
// Request channel between the poller sequencer and the flash bus cycle engine
`timescale 1ns/10ps
interface fsp_bus_if #(parameter int AW = 26, parameter int DW = 16);
  logic ready;
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic ack;
  logic [DW-1:0] rdata;
  modport master (input ready, ack, rdata, output req, wr, addr, wdata);
  modport engine (output ready, ack, rdata, input req, wr, addr, wdata);
endinterface

// ---- verilog/fsp_bus_cycle.sv ----
// Flash bus cycle engine: one timed read or write per request
`timescale 1ns/10ps
module fsp_bus_cycle #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request channel
  fsp_bus_if.engine bus,
  // Flash pins
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe
);
  import fsp_pkg::*;

  if (DW < 8) begin : g_dw_check
    $error("fsp_bus_cycle: DW must be at least 8");
  end

  typedef enum {FSP_B_IDLE, FSP_B_SETUP, FSP_B_STROBE, FSP_B_GAP} fsp_bstate_e;

  fsp_bstate_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic wr_q, next_wr_q;
  logic ce_q, next_ce_q, oe_q, next_oe_q, we_q, next_we_q, doe_q, next_doe_q;
  logic [AW-1:0] addr_q, next_addr_q;
  logic [DW-1:0] dout_q, next_dout_q, rdata_q, next_rdata_q;
  logic ack_q, next_ack_q;
  logic [DW-1:0] sync1, sync2, sync3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin and channel outputs, all from flip-flops except ready
  assign flash_ce_b = ce_q;
  assign flash_oe_b = oe_q;
  assign flash_we_b = we_q;
  assign flash_addr = addr_q;
  assign dq_out = dout_q;
  assign dq_oe = doe_q;
  assign bus.ready = (state == FSP_B_IDLE);
  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for one bus cycle
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr_q = wr_q;
    next_ce_q = ce_q;
    next_oe_q = oe_q;
    next_we_q = we_q;
    next_doe_q = doe_q;
    next_addr_q = addr_q;
    next_dout_q = dout_q;
    next_rdata_q = rdata_q;
    next_ack_q = 1'b0;
    case (state)
      FSP_B_IDLE: begin
        if (bus.req) begin
          // Address settles one cycle before any strobe falls
          next_addr_q = bus.addr;
          next_dout_q = bus.wdata;
          next_wr_q = bus.wr;
          next_doe_q = bus.wr;
          next_state = FSP_B_SETUP;
        end
      end
      FSP_B_SETUP: begin
        next_ce_q = 1'b0;
        if (wr_q) begin
          next_we_q = 1'b0;
          next_cnt = CNT_W'(WE_LOW_CYC - 1);
        end else begin
          next_oe_q = 1'b0;
          next_cnt = CNT_W'(ACC_CYC + SYNC_STAGES - 1); // Access time plus synchroniser depth
        end
        next_state = FSP_B_STROBE;
      end
      FSP_B_STROBE: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (wr_q) begin
          next_we_q = 1'b1;
          next_ce_q = 1'b1;
          next_ack_q = 1'b1;
          next_cnt = CNT_W'(BUS_HIGH_CYC - 1);
          next_state = FSP_B_GAP;
        end else if (sync2 == sync3) begin
          // Strobes rise after every read so each toggle bit advances once [RULE22]
          next_rdata_q = sync3;
          next_oe_q = 1'b1;
          next_ce_q = 1'b1;
          next_ack_q = 1'b1;
          next_cnt = CNT_W'(BUS_HIGH_CYC - 1);
          next_state = FSP_B_GAP;
        end
      end
      FSP_B_GAP: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_doe_q = 1'b0;
          next_state = FSP_B_IDLE;
        end
      end
      default: begin
        next_state = FSP_B_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, including the three-stage data synchroniser
  always_ff @(posedge clk) begin
    sync1 <= dq_in;
    sync2 <= sync1;
    sync3 <= sync2;
    if (!rst_b) begin
      state <= FSP_B_IDLE;
      cnt <= '0;
      wr_q <= 1'b0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      doe_q <= 1'b0;
      addr_q <= '0;
      dout_q <= '0;
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr_q <= next_wr_q;
      ce_q <= next_ce_q;
      oe_q <= next_oe_q;
      we_q <= next_we_q;
      doe_q <= next_doe_q;
      addr_q <= next_addr_q;
      dout_q <= next_dout_q;
      rdata_q <= next_rdata_q;
      ack_q <= next_ack_q;
    end
  end
endmodule

// ---- verilog/fsp_poller.sv ----
// Host-side flash status poller: data polling, toggle polling and recovery
`timescale 1ns/10ps
module fsp_poller #(
  parameter int AW = 26,
  parameter int DW = 16,
  parameter int POLL_LIMIT = 65535
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User command port
  input wire logic start,
  input wire fsp_pkg::fsp_method_e method,
  input wire logic [AW-1:0] poll_addr,
  input wire logic expected_value,
  input wire logic watch_abort,
  // User status port
  output logic busy,
  output logic done,
  output fsp_pkg::fsp_result_e result,
  output logic [7:0] status_byte,
  // Flash pins
  output logic flash_rst_b,
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe
);
  import fsp_pkg::*;

  // The unlock addresses need at least 12 address bits
  if (POLL_LIMIT < 1 || POLL_LIMIT > 65535 || AW < 12) begin : g_limit_check
    $error("fsp_poller: POLL_LIMIT must lie in 1..65535 and AW be at least 12");
  end

  typedef enum {FSP_P_WAKE, FSP_P_IDLE, FSP_P_READ_A, FSP_P_READ_B, FSP_P_RECOVER, FSP_P_DONE} fsp_pstate_e;

  fsp_bus_if #(.AW(AW), .DW(DW)) bus ();

  fsp_pstate_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic issued, next_issued;
  logic recheck, next_recheck;
  logic [1:0] seq, next_seq;
  logic method_tog, next_method_tog;
  logic [AW-1:0] addr_q, next_addr_q;
  logic exp_q, next_exp_q, abort_en, next_abort_en;
  logic [7:0] first_q, next_first_q, stat_q, next_stat_q;
  fsp_result_e res_q, next_res_q;
  logic done_q, next_done_q, rst_pin, next_rst_pin;
  logic [7:0] rd;
  logic fail_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Recovery sequence decoding
  function automatic logic [AW-1:0] seq_addr(input logic [1:0] idx);
    seq_addr = (idx == 2'h1) ? AW'(ADDR_UNLOCK_B) : AW'(ADDR_UNLOCK_A);
  endfunction

  function automatic logic [7:0] seq_data(input logic [1:0] idx);
    case (idx)
      2'h0: seq_data = CMD_UNLOCK_A;
      2'h1: seq_data = CMD_UNLOCK_B;
      default: seq_data = CMD_READ_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine
  fsp_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .bus(bus.engine),
    .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b),
    .flash_addr(flash_addr),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and request channel
  assign busy = (state != FSP_P_IDLE);
  assign done = done_q;
  assign result = res_q;
  assign status_byte = stat_q;
  assign flash_rst_b = rst_pin;
  assign rd = bus.rdata[7:0]; // Status sits on the low byte [RULE1]
  assign bus.req = !issued && bus.ready && (state == FSP_P_READ_A || state == FSP_P_READ_B ||
                   state == FSP_P_RECOVER);
  assign bus.wr = (state == FSP_P_RECOVER);
  assign bus.addr = (state == FSP_P_RECOVER) ? seq_addr(seq) : addr_q;
  assign bus.wdata = DW'(seq_data(seq));
  // Only error and, where defined, abort are looked at [RULE20]
  assign fail_seen = rd[POS_ERROR] || (abort_en && rd[POS_BUFFER_ABORT]);

  ////////////////////////////////////////////////////////////////////////////
  // Polling sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_issued = issued;
    next_recheck = recheck;
    next_seq = seq;
    next_method_tog = method_tog;
    next_addr_q = addr_q;
    next_exp_q = exp_q;
    next_abort_en = abort_en;
    next_first_q = first_q;
    next_stat_q = stat_q;
    next_res_q = res_q;
    next_done_q = 1'b0;
    next_rst_pin = 1'b1;
    if (bus.req) begin
      next_issued = 1'b1;
    end
    if (bus.ack) begin
      next_issued = 1'b0;
    end
    case (state)
      FSP_P_WAKE: begin
        // Hold off every access until the device has woken up [RULE21]
        if (cnt == CNT_W'(WAKE_CYC - 1)) begin
          next_cnt = '0;
          next_state = FSP_P_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      FSP_P_IDLE: begin
        if (start) begin
          // Caller gives the last programmed or an erasing-block address [RULE18] [RULE6]
          next_addr_q = poll_addr;
          next_exp_q = expected_value;
          next_abort_en = watch_abort;
          next_method_tog = (method == FSP_METHOD_TOGGLE); // Blank check goes here [RULE19]
          next_recheck = 1'b0;
          next_cnt = '0;
          next_state = FSP_P_READ_A;
        end
      end
      FSP_P_READ_A: begin
        if (bus.ack) begin
          next_first_q = rd;
          next_stat_q = rd;
          if (method_tog) begin
            next_state = FSP_P_READ_B;
          end else if (rd[POS_COMPLETION] == exp_q) begin
            // Completion bit matches the data: operation over [RULE2] [RULE3] [RULE4] [RULE17]
            next_res_q = FSP_RES_PASS;
            next_state = FSP_P_DONE;
          end else if (recheck) begin
            next_res_q = first_q[POS_ERROR] ? FSP_RES_ERROR : FSP_RES_ABORT;
            next_seq = first_q[POS_ERROR] ? SEQ_LAST : SEQ_FULL_START;
            next_state = FSP_P_RECOVER;
          end else if (fail_seen) begin
            // Re-read once: the operation may have ended with the failure flag [RULE9] [RULE13]
            next_recheck = 1'b1;
          end else if (cnt == CNT_W'(POLL_LIMIT - 1)) begin
            next_res_q = FSP_RES_TIMEOUT;
            next_state = FSP_P_DONE;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      FSP_P_READ_B: begin
        if (bus.ack) begin
          next_stat_q = rd;
          if (rd[POS_PRIMARY_TOGGLE] == first_q[POS_PRIMARY_TOGGLE]) begin
            // Toggle has stopped: done, suspended or back in read mode [RULE7] [RULE8] [RULE15]
            next_res_q = FSP_RES_PASS;
            next_state = FSP_P_DONE;
          end else if (recheck) begin
            next_res_q = first_q[POS_ERROR] ? FSP_RES_ERROR : FSP_RES_ABORT;
            next_seq = first_q[POS_ERROR] ? SEQ_LAST : SEQ_FULL_START;
            next_state = FSP_P_RECOVER;
          end else if (fail_seen) begin
            next_recheck = 1'b1;
            next_state = FSP_P_READ_A;
          end else if (cnt == CNT_W'(POLL_LIMIT - 1)) begin
            next_res_q = FSP_RES_TIMEOUT;
            next_state = FSP_P_DONE;
          end else begin
            next_cnt = cnt + 1'b1;
            next_state = FSP_P_READ_A;
          end
        end
      end
      FSP_P_RECOVER: begin
        // Error needs read/reset alone, abort the full three cycles [RULE10] [RULE14]
        if (bus.ack) begin
          if (seq == SEQ_LAST) begin
            next_state = FSP_P_DONE;
          end else begin
            next_seq = seq + 2'h1;
          end
        end
      end
      FSP_P_DONE: begin
        // Wait for the last cycle's recovery gap before reporting
        if (bus.ready && !issued) begin
          next_done_q = 1'b1;
          next_state = FSP_P_IDLE;
        end
      end
      default: begin
        next_state = FSP_P_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers; device reset pin held low with ours
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= FSP_P_WAKE;
      cnt <= '0;
      issued <= 1'b0;
      recheck <= 1'b0;
      seq <= SEQ_FULL_START;
      method_tog <= 1'b0;
      addr_q <= '0;
      exp_q <= 1'b0;
      abort_en <= 1'b0;
      first_q <= STATUS_RESET;
      stat_q <= STATUS_RESET;
      res_q <= FSP_RES_PASS;
      done_q <= 1'b0;
      rst_pin <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      issued <= next_issued;
      recheck <= next_recheck;
      seq <= next_seq;
      method_tog <= next_method_tog;
      addr_q <= next_addr_q;
      exp_q <= next_exp_q;
      abort_en <= next_abort_en;
      first_q <= next_first_q;
      stat_q <= next_stat_q;
      res_q <= next_res_q;
      done_q <= next_done_q;
      rst_pin <= next_rst_pin;
    end
  end
endmodule

// ---- test/fsp_flash_model.sv ----
// Behavioural flash device that answers status polls on the parallel bus
`timescale 1ns/10ps
module fsp_flash_model #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  // Flash pins
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] dq_out,
  output logic [DW-1:0] dq_in,
  // Scenario control: mode 0 idle, 1 program, 2 erase, 3 failing, 4 aborted, 5 erase suspend
  input wire logic arm,
  input wire logic [2:0] mode,
  input wire logic [3:0] busy_reads,
  input wire logic [7:0] stored,
  output int reads,
  output int writes,
  output logic [7:0] last_cmd,
  output logic [AW-1:0] last_addr
);
  logic [3:0] left = 4'h0;
  logic tog = 1'h0;
  logic alt = 1'h0;
  logic st;
  logic c7;
  logic [DW-1:0] drive;
  logic [DW-1:0] last = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Each arm pulse starts a fresh embedded operation
  always @(posedge arm) begin
    left = busy_reads;
    reads = 0;
    writes = 0;
  end
  // Status while busy, array data once done; in suspend, address bit 16 clear marks the erasing block
  assign st = (mode == 3'h5) ? !addr[16] : (mode >= 3'h3) || (mode != 3'h0 && left != 4'h0);
  // Completion bit: erase 0, suspend 0 until it takes effect, otherwise the inverted data
  assign c7 = (mode == 3'h2) ? 1'h0 : (mode == 3'h5) ? (left == 4'h0) : ~stored[7];
  always_comb begin
    if (st) begin
      drive = {{(DW-8){1'h0}}, c7, tog, mode == 3'h3, 1'h0,
               mode == 3'h2, alt, mode == 3'h4, 1'h0};
    end else begin
      drive = {{(DW-8){1'h0}}, (mode == 3'h2) ? 8'hFF : stored};
    end
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign dq_in = (rst_b === 1'h1 && !ce_b && !oe_b) ? drive : ~last;
  ////////////////////////////////////////////////////////////////////////////
  // A completed status read advances the primary toggle until suspended, the alternative one only in an erasing block
  always @(posedge oe_b) begin
    if (rst_b === 1'h1 && we_b === 1'h1) begin
      last = drive;
      reads = reads + 1;
      tog = tog ^ (st && !(mode == 3'h5 && left == 4'h0));
      alt = alt ^ (st && (mode == 3'h2 || mode == 3'h5) && addr[16] == 1'h0);
      left = (left != 4'h0 && (mode < 3'h3 || mode == 3'h5)) ? left - 4'h1 : left;
    end
  end
  // Device reset abandons the operation and clears both toggles
  always @(negedge rst_b) begin
    left = 4'h0;
    tog = 1'h0;
    alt = 1'h0;
  end
  // Command writes are logged for the recovery checks
  always @(posedge we_b) begin
    if (rst_b === 1'h1 && oe_b === 1'h1) begin
      writes = writes + 1;
      last_cmd = dq_out[7:0];
      last_addr = addr;
    end
  end
endmodule

// ---- test/fsp_poller_chk.sv ----
// Bus-timing checker for the flash status poller
`timescale 1ns/10ps
module fsp_poller_chk #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User status
  input wire logic busy,
  input wire logic done,
  // Flash pins
  input wire logic flash_rst_b,
  input wire logic flash_ce_b,
  input wire logic flash_oe_b,
  input wire logic flash_we_b,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read strobe held with a steady address
  sequence s_read_low;
    (!flash_ce_b && !flash_oe_b && $stable(flash_addr)) [*5];
  endsequence
  // Write strobe released with data still driven
  sequence s_write_end;
    flash_we_b && flash_ce_b && dq_oe;
  endsequence
  a_read_width: assert property ($fell(flash_oe_b) |-> s_read_low)
    else $error("read strobe too short");
  a_read_end: assert property ($rose(flash_oe_b) |-> $rose(flash_ce_b) && flash_we_b)
    else $error("read did not end on both strobes");
  a_write_pulse: assert property ($fell(flash_we_b) |-> !flash_ce_b && dq_oe && flash_oe_b ##1 s_write_end)
    else $error("bad write pulse");
  a_write_hold: assert property ($rose(flash_we_b) |-> dq_oe && $stable(dq_out))
    else $error("write data not held");
  a_strobe_excl: assert property (flash_oe_b || flash_we_b)
    else $error("read and write strobes together");
  a_ce_owner: assert property (!flash_ce_b |-> !flash_oe_b || !flash_we_b)
    else $error("chip enable without strobe");
  a_read_quiet: assert property (!flash_oe_b |-> !dq_oe)
    else $error("data driven during read");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_wake_state: assert property ($rose(rst_b) |-> flash_ce_b && flash_oe_b && flash_we_b && !dq_oe && !done
    && !flash_rst_b ##1 flash_rst_b)
    else $error("bad state leaving reset");
  a_wake_busy: assert property ($rose(rst_b) |-> busy [*8])
    else $error("busy dropped during wake-up");
endmodule
bind fsp_poller fsp_poller_chk #(.AW(AW), .DW(DW)) i_fsp_poller_chk (.clk(clk), .rst_b(rst_b), .busy(busy),
  .done(done), .flash_rst_b(flash_rst_b), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
  .flash_we_b(flash_we_b), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe));

// ---- test/test_fsp_poller.sv ----
// Self-checking bench for the flash status poller
`timescale 1ns/10ps
module test_fsp_poller;
  import fsp_pkg::*;
  localparam int AW = 26;
  localparam int DW = 16;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic start = 1'h0;
  fsp_method_e method = FSP_METHOD_DATA;
  logic [AW-1:0] poll_addr = '0;
  logic expected_value = 1'h0;
  logic watch_abort = 1'h0;
  logic busy, done, flash_rst_b, flash_ce_b, flash_oe_b, flash_we_b, dq_oe, arm = 1'h0;
  fsp_result_e result;
  logic [7:0] status_byte, last_cmd, stored = 8'h00;
  logic [AW-1:0] flash_addr, last_addr;
  logic [DW-1:0] dq_in, dq_out;
  logic [2:0] mode = 3'h0;
  logic [3:0] busy_reads = 4'h0;
  int reads, writes, fails = 0, checked = 0, seed = 10813;
  // 10 MHz clock
  always #50 clk = ~clk;
  fsp_poller #(.AW(AW), .DW(DW), .POLL_LIMIT(8)) i_fsp_poller (.clk(clk), .rst_b(rst_b), .start(start),
    .method(method), .poll_addr(poll_addr), .expected_value(expected_value), .watch_abort(watch_abort),
    .busy(busy), .done(done), .result(result), .status_byte(status_byte), .flash_rst_b(flash_rst_b),
    .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_addr(flash_addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  fsp_flash_model #(.AW(AW), .DW(DW)) i_fsp_flash_model (.rst_b(flash_rst_b), .ce_b(flash_ce_b),
    .oe_b(flash_oe_b), .we_b(flash_we_b), .addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in), .arm(arm),
    .mode(mode), .busy_reads(busy_reads), .stored(stored), .reads(reads), .writes(writes),
    .last_cmd(last_cmd), .last_addr(last_addr));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask
  // Bounded wait for done or for busy low
  task automatic wait_sig(input bit want_done, input int limit);
    int n;
    n = 0;
    while ((want_done ? done !== 1'h1 : busy !== 1'h0) && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= limit) begin
      chk(16'h0000, 16'h0001, "wait ran out");
      stop_test();
    end
  endtask
  // Outcome expected for one operation
  function automatic fsp_result_e exp_result(input logic [2:0] md, input logic [3:0] n, input logic wa);
    if (md == 3'h3) return FSP_RES_ERROR;
    if (md == 3'h4 && wa) return FSP_RES_ABORT;
    if (md == 3'h4 || n > 4'h7) return FSP_RES_TIMEOUT;
    return FSP_RES_PASS;
  endfunction
  // Arm the device, start one poll and check its outcome
  task automatic run_op(input fsp_method_e m, input logic [2:0] md, input logic [3:0] n, input logic [7:0] d,
                        input logic wa);
    fsp_result_e want;
    logic [AW-1:0] pa;
    logic [15:0] nr;
    want = exp_result(md, n, wa);
    pa = AW'($random(seed));
    if (md == 3'h5) pa[16] = d[0]; // Suspend cases pick the block by the low data bit
    nr = (md == 3'h5 && pa[16]) ? 16'h0001 : 16'(n) + 16'h0001;
    @(posedge clk);
    mode <= md;
    busy_reads <= n;
    stored <= d;
    arm <= 1'h1;
    method <= m;
    poll_addr <= pa;
    expected_value <= (md == 3'h2 || (md == 3'h5 && !pa[16])) ? 1'h1 : d[7];
    watch_abort <= wa;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    arm <= 1'h0;
    wait_sig(1, 3000);
    chk(16'(result), 16'(want), "result");
    if (want == FSP_RES_PASS && md == 3'h5 && !pa[16]) begin
      chk(16'(status_byte[7]), 16'h0001, "suspended");
    end else if (want == FSP_RES_PASS) begin
      chk(16'(status_byte), (md == 3'h2) ? 16'h00FF : 16'(d), "final byte");
    end
    if (want == FSP_RES_PASS && m == FSP_METHOD_DATA) chk(16'(reads), nr, "reads");
    if (want == FSP_RES_ERROR || want == FSP_RES_ABORT) begin
      chk(16'(writes), (want == FSP_RES_ERROR) ? 16'h0001 : 16'h0003, "recovery writes");
      chk(16'(last_cmd), 16'(CMD_READ_RESET), "recovery command");
      chk(16'(last_addr), 16'(ADDR_UNLOCK_A), "recovery address");
    end
    wait_sig(0, 10);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: corner cases, random programs and erases, reset mid-poll
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    wait_sig(0, 600);
    chk(16'(status_byte), 16'h0000, "status after reset");
    run_op(FSP_METHOD_DATA, 3'h1, 4'h7, 8'hA5, 1'h1);
    run_op(FSP_METHOD_DATA, 3'h1, 4'hF, 8'h5A, 1'h0);
    run_op(FSP_METHOD_DATA, 3'h3, 4'h2, 8'h80, 1'h1);
    run_op(FSP_METHOD_TOGGLE, 3'h3, 4'h2, 8'h80, 1'h1);
    run_op(FSP_METHOD_DATA, 3'h4, 4'h2, 8'h00, 1'h1);
    run_op(FSP_METHOD_DATA, 3'h4, 4'h2, 8'h00, 1'h0);
    run_op(FSP_METHOD_TOGGLE, 3'h2, 4'h0, 8'h00, 1'h0);
    run_op(FSP_METHOD_DATA, 3'h5, 4'h3, 8'h3C, 1'h0);
    run_op(FSP_METHOD_TOGGLE, 3'h5, 4'h2, 8'h3C, 1'h0);
    run_op(FSP_METHOD_DATA, 3'h5, 4'h2, 8'hC3, 1'h0);
    repeat (14) begin
      run_op(fsp_method_e'($random(seed) & 1), 3'h1 + 3'($random(seed) & 1), 4'({$random(seed)} % 6),
             8'($random(seed)), 1'($random(seed)));
    end
    @(posedge clk);
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    wait_sig(0, 600);
    chk(16'(status_byte), 16'h0000, "status after second reset");
    stop_test();
  end
endmodule
